/* File: bench/far_end_model.sv */
/*
  Far-end equipment: add-bus source, HDLC terminal, low-rate tributary.
  Mode from the bench: 0 HDLC, 1 add bus, 2 low-rate add, 3 released.
*/
`timescale 1ns/1ps
module far_end_model (
  // Control from bench
  input wire logic [1:0] mode,
  input wire logic en,
  // Device clock
  input wire logic hdlc_clk,
  // Lines toward device
  output logic lane,
  output logic [6:0] other_bits,
  output logic add_clk,
  output logic lr_clk,
  output logic lr_pos
);
  // Framed sources: clocks stand low between bursts
  initial begin
    {lane, other_bits, add_clk, lr_clk, lr_pos} = '0;
    forever begin
      wait (en && mode inside {2'h1, 2'h2});
      {other_bits, lane, lr_pos} = 9'($urandom);
      if (mode == 2'h1) begin
        add_clk = 1'b1;
        #80 add_clk = 1'b0;
        #80;
      end else begin
        #80 lr_clk = 1'b1;
        #80 lr_clk = 1'b0;
      end
    end
  end
  // New byte once the device clock falls
  always @(negedge hdlc_clk) begin
    if (mode == 2'h0) begin
      {other_bits, lane} = 8'($urandom);
    end
  end
  // Released lane never rests at a level
  always #20 begin
    if (mode == 2'h3) begin
      lane = ~lane;
    end
  end
endmodule

/* File: bench/lane3_mux_bench.sv */
/*
  Self-checking bench for lane3_mux with far-end model and port checker.
  Assumes hready loops back from the single slave's hreadyout.
*/
`timescale 1ns/1ps
module lane3_mux_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd_q;
  logic hreadyout, hresp, neg_o, neg_oe_n, pos_o, pos_oe_n, pc_o, pc_oe_n, hdlc_clk, cap_valid, drop_ready;
  logic cap_ready = 1'b0;
  logic drop_valid = 1'b0;
  logic drop_pos = 1'b0;
  logic drop_neg = 1'b0;
  logic [1:0] m = 2'h0;
  logic en = 1'b0;
  logic stall = 1'b0;
  logic lane, add_clk, lr_clk, lr_pos;
  logic [6:0] ob;
  lane_mux_pkg::cap_word_t cap_word;
  lane_mux_pkg::cap_word_t exp_q[$];
  lane_mux_pkg::cap_word_t exp_w = '0;
  int err_total = 0;
  int n_tests = 0;
  int n_drop = 0;
  // Pin levels: device drive wins when enabled
  wire neg_w = !neg_oe_n ? neg_o : lane;
  wire pos_w = !pos_oe_n ? pos_o : lr_pos;
  wire pc_w = !pc_oe_n ? pc_o : lr_clk;
  always #10 hclk = ~hclk;
  lane3_mux u_lane3_mux (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .lowrate_neg_rail_i(neg_w), .lowrate_neg_rail_o(neg_o),
    .lowrate_neg_rail_oe_n(neg_oe_n), .lowrate_pos_rail_i(pos_w), .lowrate_pos_rail_o(pos_o),
    .lowrate_pos_rail_oe_n(pos_oe_n), .lowrate_port_clock_i(pc_w), .lowrate_port_clock_o(pc_o),
    .lowrate_port_clock_oe_n(pc_oe_n), .add_bus_ch2_clock(add_clk), .byte_other_bits(ob),
    .hdlc_tx_ch2_byte_clock(hdlc_clk), .cap_valid(cap_valid), .cap_word(cap_word),
    .cap_ready(cap_ready), .drop_valid(drop_valid), .drop_pos(drop_pos), .drop_neg(drop_neg),
    .drop_ready(drop_ready));
  far_end_model u_far_end_model (.mode(m), .en(en), .hdlc_clk(hdlc_clk), .lane(lane),
    .other_bits(ob), .add_clk(add_clk), .lr_clk(lr_clk), .lr_pos(lr_pos));
  // ----------------------------------------
  // Compare, bus and closing tasks
  // ----------------------------------------
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_cap(input lane_mux_pkg::cap_word_t got, input lane_mux_pkg::cap_word_t exp);
    chk_reg(32'(got), 32'(exp));
  endtask
  task automatic chk_rail(input logic [2:0] got, input logic [2:0] exp);
    chk_reg(32'(got), 32'(exp));
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_q = hrdata;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] mask, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk_reg(rd_q & mask, exp);
  endtask
  task automatic drain();
    repeat (400) begin
      @(posedge hclk);
      if (exp_q.size() == 0) break;
    end
    chk_reg(32'(exp_q.size()), 32'h0);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic logic [7:0] lane_byte();
    return {ob[6:3], lane, ob[2:0]};
  endfunction
  // Reference model: bytes at each sampling edge
  always @(posedge hdlc_clk) if (m == 2'h0) exp_q.push_back({lane_mux_pkg::ROLE_HDLC, lane_byte()});
  always @(negedge add_clk) if (m == 2'h1) exp_q.push_back({lane_mux_pkg::ROLE_ADD_BUS, lane_byte()});
  always @(posedge lr_clk) if (m == 2'h2) exp_q.push_back({lane_mux_pkg::ROLE_LR_ADD, 6'h0, lr_pos, lane});
  // Stream consumer and drop source
  always @(posedge hclk) begin
    if (cap_valid === 1'b1 && cap_ready === 1'b1) begin
      exp_w = exp_q.size() > 0 ? exp_q.pop_front() : 11'h7FF;
      chk_cap(cap_word, exp_w);
    end
    if (drop_ready === 1'b1) begin
      drop_pos <= 1'($urandom);
      drop_neg <= 1'($urandom);
    end
    cap_ready <= !stall && 1'($urandom);
  end
  // Rails and port clock at each drop
  always @(negedge hclk) begin
    if (drop_ready === 1'b1) begin
      chk_rail({pos_w, neg_w, pc_w}, {drop_pos, drop_neg, 1'b0});
      n_drop++;
    end
  end
  // Main sequence
  initial begin
    void'($urandom(43169));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(32'h0, 32'hF, 32'h0);
    rd_chk(32'h4, 32'h7, 32'h2);
    rd_chk(32'h10, 32'hFFFF_FFFF, 32'h0);
    ahb(1'b1, 32'h4, 32'hFFFF_FFFF);
    rd_chk(32'h4, 32'hFF00, 32'h0);
    $display("registers done");
    repeat (300) @(posedge hclk);
    stall <= 1'b1;
    repeat (100) @(posedge hclk);
    rd_chk(32'h4, 32'hFF20, 32'h20);
    m <= 2'h1;
    ahb(1'b1, 32'h0, 32'h1);
    stall <= 1'b0;
    drain();
    $display("hdlc done");
    en = 1'b1;
    repeat (300) @(posedge hclk);
    en = 1'b0;
    drain();
    stall <= 1'b1;
    en = 1'b1;
    repeat (5) @(negedge add_clk);
    en = 1'b0;
    repeat (20) @(posedge hclk);
    rd_chk(32'h4, 32'hFF00, 32'h300);
    while (exp_q.size() > 2) void'(exp_q.pop_back());
    stall <= 1'b0;
    drain();
    $display("add bus done");
    m <= 2'h2;
    ahb(1'b1, 32'h0, 32'h2);
    rd_chk(32'h4, 32'h7, 32'h3);
    en = 1'b1;
    repeat (300) @(posedge hclk);
    en = 1'b0;
    drain();
    rd_chk(32'h8, 32'hFF, {24'h00_0000, exp_w.data});
    $display("lowrate add done");
    m <= 2'h3;
    drop_valid <= 1'b1;
    ahb(1'b1, 32'h0, 32'hA);
    rd_chk(32'h4, 32'h7, 32'h4);
    repeat (80) @(posedge hclk);
    chk_reg(32'(n_drop > 8), 32'h1);
    $display("lowrate drop done");
    drop_valid <= 1'b0;
    ahb(1'b1, 32'h0, 32'h4);
    repeat (10) @(posedge hclk);
    chk_rail({pc_oe_n, neg_oe_n, hdlc_clk}, 3'h6);
    rd_chk(32'h0, 32'hF, 32'h4);
    rd_chk(32'h4, 32'h7, 32'h0);
    $display("mode off done");
    conclude();
  end
  // Watchdog against a hang
  initial begin
    #200000;
    err_total++;
    conclude();
  end
endmodule
bind lane3_mux lane3_mux_props u_lane3_mux_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .hdlc_tx_ch2_byte_clock, .lowrate_neg_rail_o,
  .lowrate_neg_rail_oe_n, .lowrate_port_clock_o, .lowrate_port_clock_oe_n, .drop_ready,
  .cap_valid, .cap_word, .cap_ready);

/* File: bench/lane3_mux_props.sv */
/*
  Port checker for lane3_mux: bus answer, HDLC clock, drop port, stream.
  Bound from the bench; sees only the top's ports and shadows CTRL.
*/
`timescale 1ns/1ps
module lane3_mux_props (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Lane side
  input wire logic hdlc_tx_ch2_byte_clock,
  input wire logic lowrate_neg_rail_o,
  input wire logic lowrate_neg_rail_oe_n,
  input wire logic lowrate_port_clock_o,
  input wire logic lowrate_port_clock_oe_n,
  input wire logic drop_ready,
  // Stream
  input wire logic cap_valid,
  input wire lane_mux_pkg::cap_word_t cap_word,
  input wire logic cap_ready
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // Shadow of the control register
  // ----------------------------------------
  logic [3:0] ctl_q;
  logic wr_q;
  logic hdlc_r;
  logic drop_r;
  assign hdlc_r = !ctl_q[0] && ctl_q[2:1] == 2'h0;
  assign drop_r = !ctl_q[0] && ctl_q[3:1] == 3'h5;
  // Follows CTRL writes at their data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_q <= 4'h0;
      wr_q <= 1'b0;
    end else begin
      if (wr_q) begin
        ctl_q <= hwdata[3:0];
      end
      wr_q <= hsel && htrans[1] && hready && hwrite && haddr == lane_mux_pkg::CTRL_OFFSET;
    end
  end
  sequence high4_s;
    hdlc_tx_ch2_byte_clock [*4] ##1 !hdlc_tx_ch2_byte_clock;
  endsequence
  sequence left_s;
    ##[0:4] !hdlc_r;
  endsequence
  bus_okay_a: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  zero_wait_a: assert property (hsel && htrans[1] |=> hreadyout)
    else $error("wait state inserted");
  hdlc_half_a: assert property ($rose(hdlc_tx_ch2_byte_clock) |-> high4_s or left_s)
    else $error("hdlc clock high phase wrong");
  hdlc_idle_a: assert property (!hdlc_r [*3] |-> !hdlc_tx_ch2_byte_clock)
    else $error("hdlc clock outside hdlc role");
  drop_off_a: assert property (!drop_r [*2] |-> lowrate_neg_rail_oe_n && lowrate_port_clock_oe_n)
    else $error("lane driven outside drop role");
  drop_drive_a: assert property (drop_r [*2] |-> !lowrate_neg_rail_oe_n && !lowrate_port_clock_oe_n)
    else $error("drop port not driven");
  rail_edge_a: assert property (!lowrate_neg_rail_oe_n && $changed(lowrate_neg_rail_o) |-> $fell(lowrate_port_clock_o))
    else $error("rail moved off falling edge");
  drop_pulse_a: assert property (drop_ready |-> $fell(lowrate_port_clock_o) ##1 !drop_ready)
    else $error("drop ready misplaced");
  cap_hold_a: assert property (cap_valid && !cap_ready |=> cap_valid && $stable(cap_word))
    else $error("stalled word lost");
endmodule

/* File: core/cap_buffer.sv */
/*
  Two-entry buffer with valid/ready on both sides for captured words.
  Assumes a single clock; outputs come straight from flip-flops.
*/
`timescale 1ns/1ps
module cap_buffer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  input wire lane_mux_pkg::cap_word_t in_word,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output lane_mux_pkg::cap_word_t out_word,
  input wire logic out_ready
);

  typedef struct packed {
    lane_mux_pkg::cap_word_t head;
    lane_mux_pkg::cap_word_t tail;
    logic head_v;
    logic tail_v;
  } buf_state_t;

  buf_state_t b_q;
  buf_state_t b_d;

  // Pop moves tail to head, push fills first free slot
  always_comb begin
    b_d = b_q;
    if (b_q.head_v && out_ready) begin
      b_d.head = b_q.tail;
      b_d.head_v = b_q.tail_v;
      b_d.tail_v = 1'b0;
    end
    if (in_valid && !b_q.tail_v) begin
      if (!b_d.head_v) begin
        b_d.head = in_word;
        b_d.head_v = 1'b1;
      end else begin
        b_d.tail = in_word;
        b_d.tail_v = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      b_q <= '0;
    end else begin
      b_q <= b_d;
    end
  end

  assign in_ready = !b_q.tail_v;
  assign out_valid = b_q.head_v;
  assign out_word = b_q.head;

endmodule

/* File: core/lane3_mux.sv */
/*
  Channel 2 transmit-side shared lane 3: add-bus data bit, HDLC byte bit,
  or negative rail of the low-rate tributary port, chosen by a control
  register reached over AHB-Lite. Captured units go out through a two-entry
  buffer; dropped tributary data comes in from internal logic.
  Assumes pins and the add-bus and low-rate clocks are asynchronous to hclk
  and slow enough (160 ns period) to be sampled by edge detection.
*/
`timescale 1ns/1ps

// Behaviour
// R1 - Lane role follows add-bus enable first, then the configured operating mode.
// R2 - Add bus enabled: lane is input bit 3 of the eight-bit add byte.
// R3 - Add bus: lane is captured on every falling edge of the add-bus clock.
// R4 - HDLC mode, add bus off: lane is input bit 3 of HDLC byte.
// R5 - HDLC mode: device drives a byte-rate transmit clock to the terminal.
// R6 - HDLC mode: whole byte is captured on each rising edge of that clock.
// R7 - Mapper mode: lane is negative rail of low-rate port, add or drop.
// R8 - Add port: external tributary signal is inserted into the ingress channel.
// R9 - Add port: lane carries the negative-polarity portion of the signal.
// R10 - Add port: negative rail sampled on each rising edge of port clock.
// R11 - Drop port: lane drives negative portion of the selected ingress channel.
// R12 - Drop port: rail changes only on falling edges of device-driven port clock.
// R13 - Far side holds input lanes stable around the governing sampling edge.
module lane3_mux (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Shared lane 3 pin
  input wire logic lowrate_neg_rail_i,
  output logic lowrate_neg_rail_o,
  output logic lowrate_neg_rail_oe_n,
  // Low-rate positive rail pin
  input wire logic lowrate_pos_rail_i,
  output logic lowrate_pos_rail_o,
  output logic lowrate_pos_rail_oe_n,
  // Low-rate port clock pin
  input wire logic lowrate_port_clock_i,
  output logic lowrate_port_clock_o,
  output logic lowrate_port_clock_oe_n,
  // Add bus clock and remaining byte bits 7:4, 2:0
  input wire logic add_bus_ch2_clock,
  input wire logic [6:0] byte_other_bits,
  // HDLC byte clock output
  output logic hdlc_tx_ch2_byte_clock,
  // Captured stream toward internal logic
  output logic cap_valid,
  output lane_mux_pkg::cap_word_t cap_word,
  input wire logic cap_ready,
  // Drop stream from internal logic
  input wire logic drop_valid,
  input wire logic drop_pos,
  input wire logic drop_neg,
  output logic drop_ready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    lane_mux_pkg::ctrl_t ctrl;
    logic a_wr;
    logic [31:0] a_addr;
    logic [31:0] rdata;
    logic ready_out;
    logic add_clk_prev;
    logic lr_clk_prev;
    logic [3:0] hdlc_cnt;
    logic hdlc_clk;
    logic [1:0] hdlc_rise_pipe;
    logic [3:0] lr_cnt;
    logic lr_clk;
    logic neg_o;
    logic pos_o;
    logic drive_n;
    logic push;
    lane_mux_pkg::cap_word_t push_word;
    logic [7:0] lost_cnt;
    logic [7:0] last_byte;
    logic drop_rdy;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;

  lane_mux_pkg::pin_in_t pins_async;
  lane_mux_pkg::pin_in_t pins;
  lane_mux_pkg::lane_role_t role;
  logic [7:0] byte_now;
  logic buf_in_ready;
  logic buf_out_valid;
  lane_mux_pkg::cap_word_t buf_out_word;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  assign pins_async = '{add_clk: add_bus_ch2_clock, lr_clk: lowrate_port_clock_i,
                        lr_pos: lowrate_pos_rail_i, lane: lowrate_neg_rail_i,
                        other_bits: byte_other_bits};

  sync2 #(
    .W($bits(lane_mux_pkg::pin_in_t))
  ) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .async_in(pins_async),
    .sync_out(pins)
  );

  // Lane 3 sits between bits 7:4 and 2:0 of the byte
  assign byte_now = {pins.other_bits[6:3], pins.lane, pins.other_bits[2:0]}; // R2 R4

  // Role decode: add bus wins over the mode setting
  always_comb begin
    role = lane_mux_pkg::ROLE_IDLE;
    if (s_q.ctrl.add_bus_en) begin // R1
      role = lane_mux_pkg::ROLE_ADD_BUS;
    end else if (s_q.ctrl.mode == lane_mux_pkg::MODE_HDLC) begin
      role = lane_mux_pkg::ROLE_HDLC;
    end else if (s_q.ctrl.mode == lane_mux_pkg::MODE_MAPPER) begin // R7
      role = s_q.ctrl.lowrate_drop ? lane_mux_pkg::ROLE_LR_DROP : lane_mux_pkg::ROLE_LR_ADD;
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.push = 1'b0;
    s_d.drop_rdy = 1'b0;
    s_d.add_clk_prev = pins.add_clk;
    s_d.lr_clk_prev = pins.lr_clk;
    s_d.hdlc_rise_pipe = {s_q.hdlc_rise_pipe[0], 1'b0};

    // Bus address phase: zero wait, latch write, prepare read data
    s_d.ready_out = 1'b1;
    s_d.a_wr = 1'b0;
    if (hsel && htrans[1] && hready) begin
      s_d.a_wr = hwrite;
      s_d.a_addr = haddr;
      s_d.rdata = '0;
      if (!hwrite) begin
        unique case (haddr)
          lane_mux_pkg::CTRL_OFFSET: s_d.rdata = 32'(s_q.ctrl);
          lane_mux_pkg::STATUS_OFFSET: begin
            s_d.rdata[lane_mux_pkg::STAT_ROLE_LSB +: 3] = role;
            s_d.rdata[lane_mux_pkg::STAT_BUF_LSB] = buf_out_valid;
            s_d.rdata[lane_mux_pkg::STAT_BUF_LSB + 1] = !buf_in_ready;
            s_d.rdata[lane_mux_pkg::STAT_LOST_LSB +: 8] = s_q.lost_cnt;
          end
          lane_mux_pkg::LAST_OFFSET: s_d.rdata = {24'h00_0000, s_q.last_byte};
          default: s_d.rdata = '0;
        endcase
      end
    end

    // Bus data phase: control write
    if (s_q.a_wr && s_q.a_addr == lane_mux_pkg::CTRL_OFFSET) begin
      s_d.ctrl.add_bus_en = hwdata[lane_mux_pkg::CTRL_ADD_EN_BIT];
      s_d.ctrl.mode = lane_mux_pkg::op_mode_t'(hwdata[lane_mux_pkg::CTRL_MODE_LSB +: 2]);
      s_d.ctrl.lowrate_drop = hwdata[lane_mux_pkg::CTRL_DROP_BIT];
    end

    // Add bus: capture byte on falling add clock edge
    if (role == lane_mux_pkg::ROLE_ADD_BUS && s_q.add_clk_prev && !pins.add_clk) begin // R3
      s_d.push = 1'b1;
      s_d.push_word = '{src: lane_mux_pkg::ROLE_ADD_BUS, data: byte_now}; // R2
    end

    // HDLC: divided byte clock, held low while the buffer is full
    if (role == lane_mux_pkg::ROLE_HDLC) begin
      if (buf_in_ready || s_q.hdlc_clk) begin
        if (s_q.hdlc_cnt == lane_mux_pkg::HDLC_HALF_CYC - 4'h1) begin // R5
          s_d.hdlc_cnt = '0;
          s_d.hdlc_clk = !s_q.hdlc_clk;
          s_d.hdlc_rise_pipe[0] = !s_q.hdlc_clk;
        end else begin
          s_d.hdlc_cnt = s_q.hdlc_cnt + 4'h1;
        end
      end
      // Sample two cycles after the rise to cover the synchroniser delay
      if (s_q.hdlc_rise_pipe[1]) begin // R6
        s_d.push = 1'b1;
        s_d.push_word = '{src: lane_mux_pkg::ROLE_HDLC, data: byte_now}; // R4
      end
    end else begin
      s_d.hdlc_cnt = '0;
      s_d.hdlc_clk = 1'b0;
    end

    // Low-rate add: sample both rails on rising port clock
    if (role == lane_mux_pkg::ROLE_LR_ADD && !s_q.lr_clk_prev && pins.lr_clk) begin // R10
      s_d.push = 1'b1;
      s_d.push_word = '{src: lane_mux_pkg::ROLE_LR_ADD, data: {6'h00, pins.lr_pos, pins.lane}}; // R8 R9
    end

    // Low-rate drop: device makes the clock, rails change on its fall
    if (role == lane_mux_pkg::ROLE_LR_DROP) begin
      s_d.drive_n = 1'b0; // R11
      if (s_q.lr_cnt == lane_mux_pkg::LR_HALF_CYC - 4'h1) begin
        s_d.lr_cnt = '0;
        s_d.lr_clk = !s_q.lr_clk;
        if (s_q.lr_clk) begin // R12
          s_d.neg_o = drop_valid & drop_neg; // R11
          s_d.pos_o = drop_valid & drop_pos;
          s_d.drop_rdy = drop_valid;
        end
      end else begin
        s_d.lr_cnt = s_q.lr_cnt + 4'h1;
      end
    end else begin
      s_d.drive_n = 1'b1;
      s_d.lr_cnt = '0;
      s_d.lr_clk = 1'b0;
      s_d.neg_o = 1'b0;
      s_d.pos_o = 1'b0;
    end

    // Count units lost to a full buffer, saturating
    if (s_q.push) begin
      s_d.last_byte = s_q.push_word.data;
      if (!buf_in_ready && s_q.lost_cnt != 8'hFF) begin
        s_d.lost_cnt = s_q.lost_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.ctrl <= lane_mux_pkg::ctrl_t'(lane_mux_pkg::CTRL_RESET[3:0]);
      s_q.ready_out <= 1'b1;
      s_q.drive_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Capture buffer
  // ----------------------------------------------------------------
  cap_buffer u_buf (
    .clk(hclk),
    .rst_n(hresetn),
    .in_valid(s_q.push),
    .in_word(s_q.push_word),
    .in_ready(buf_in_ready),
    .out_valid(buf_out_valid),
    .out_word(buf_out_word),
    .out_ready(cap_ready)
  );

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops except hresp, tied to OKAY
  // ----------------------------------------------------------------
  assign hreadyout = s_q.ready_out;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign lowrate_neg_rail_o = s_q.neg_o;
  assign lowrate_neg_rail_oe_n = s_q.drive_n;
  assign lowrate_pos_rail_o = s_q.pos_o;
  assign lowrate_pos_rail_oe_n = s_q.drive_n;
  assign lowrate_port_clock_o = s_q.lr_clk;
  assign lowrate_port_clock_oe_n = s_q.drive_n;
  assign hdlc_tx_ch2_byte_clock = s_q.hdlc_clk;
  assign cap_valid = buf_out_valid;
  assign cap_word = buf_out_word;
  assign drop_ready = s_q.drop_rdy;

endmodule

/* File: core/sync2.sv */
/*
  Two flip-flop synchroniser for a group of levels.
  Assumes the inputs are asynchronous to clk; only the second stage is used.
*/
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  // Shift through both stages
  always_comb begin
    s_d = s_q;
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.sync;

endmodule

/* File: pkg/lane_mux_pkg.sv */
/*
  Shared constants and types for the channel 2 transmit lane 3 multiplexer:
  register map, control field layout, reset values, clock timing and the
  packed carriers that pass between the top, its buffer and its synchroniser.
  Assumes a 50 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package lane_mux_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
  localparam logic [31:0] LAST_OFFSET = 32'h0000_0008;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Control field positions
  localparam int CTRL_ADD_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_DROP_BIT = 3;

  // Status field positions
  localparam int STAT_ROLE_LSB = 0;
  localparam int STAT_BUF_LSB = 4;
  localparam int STAT_LOST_LSB = 8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int HDLC_HALF_NS = 80;
  localparam int LR_HALF_NS = 80;
  localparam logic [3:0] HDLC_HALF_CYC = 4'((HDLC_HALF_NS * CLK_MHZ) / 1000);
  localparam logic [3:0] LR_HALF_CYC = 4'((LR_HALF_NS * CLK_MHZ) / 1000);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_HDLC,
    MODE_MAPPER,
    MODE_OFF
  } op_mode_t;

  typedef enum logic [2:0] {
    ROLE_IDLE,
    ROLE_ADD_BUS,
    ROLE_HDLC,
    ROLE_LR_ADD,
    ROLE_LR_DROP
  } lane_role_t;

  typedef struct packed {
    logic lowrate_drop;
    op_mode_t mode;
    logic add_bus_en;
  } ctrl_t;

  // One captured unit: which role took it and the byte
  typedef struct packed {
    lane_role_t src;
    logic [7:0] data;
  } cap_word_t;

  // Outside-domain inputs gathered for synchronising
  typedef struct packed {
    logic add_clk;
    logic lr_clk;
    logic lr_pos;
    logic lane;
    logic [6:0] other_bits;
  } pin_in_t;

endpackage
